//--- core/mpsc_top.v
`timescale 1ns/100ps
`default_nettype none
`include "mpsc_defs.vh"

module mpsc_top (
  // clock and reset
  input wire clk,
  input wire resetn,
  // board straps
  input wire multiport_expansion,
  input wire prescale_select,
  // daisy chain
  input wire [1:0] chain_in,
  output reg [1:0] chain_out,
  // dual-role pins 3..0: input, output, output enable
  input wire [3:0] dual_pin_in,
  output reg [3:0] dual_pin_out,
  output reg [3:0] dual_pin_oe,
  // expansion address decode
  input wire [7:0] addr,
  output reg unit_hit_q,
  output reg [2:0] chan_sel_q,
  output reg [2:0] reg_sel_q,
  // captured configuration
  output reg expansion_mode_q,
  output reg [1:0] osc_freq_strap,
  output reg [1:0] line_iface_strap,
  output reg [23:0] uart_clk_hz_q,
  output reg [3:0] line_type_q,
  output reg [3:0] port_population_n,
  output reg strap_done_q,
  // prescaler
  output reg modem_control_reg_b7,
  output reg prescale_en_q
);

  // ********************************
  // input synchronisers
  // ********************************

  wire [7:0] sync_raw;
  wire [7:0] sync_lvl;
  wire mode_s;
  wire sel_s;
  wire [1:0] chain_s;
  wire [3:0] pins_s;

  // pack the asynchronous inputs; widths must add up to the instance width
  assign sync_raw = {multiport_expansion, prescale_select, chain_in, dual_pin_in};
  assign mode_s = sync_lvl[7];
  assign sel_s = sync_lvl[6];
  assign chain_s = sync_lvl[5:4];
  assign pins_s = sync_lvl[3:0];

  // one shared instance keeps all strap inputs on identical latency
  mpsc_sync3 #(
    .W(8)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(sync_raw),
    .level_q(sync_lvl)
  );

  // ********************************
  // strap capture window
  // ********************************

  reg [`MPSC_STRAP_CNT_W-1:0] strap_cnt_q;
  reg [3:0] strap_q;
  reg sel_taken_q;
  reg div4_q;
  reg [1:0] pre_cnt_q;

  // pins stay inputs while the counter runs; the value seen last is kept
  // a sixteen-cycle window leaves ample margin over the synchroniser delay
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      strap_cnt_q <= {`MPSC_STRAP_CNT_W{1'b0}};
      strap_q <= 4'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q <= pins_s;
      if (strap_cnt_q == `MPSC_STRAP_CYCLES - 5'h01) begin
        strap_done_q <= 1'b1;
      end else begin
        strap_cnt_q <= strap_cnt_q + 5'h01;
      end
    end
  end

  // ********************************
  // strap decode
  // ********************************

  // decoded copies update once, at the end of the window, from the sample
  // held one cycle before the last, while the pins were still inputs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_freq_strap <= 2'h0;
      line_iface_strap <= 2'h0;
      uart_clk_hz_q <= `MPSC_HZ_1M8;
      line_type_q <= `MPSC_LT_RS232;
    end else if (!strap_done_q && strap_cnt_q == `MPSC_STRAP_CYCLES - 5'h01) begin
      osc_freq_strap <= strap_q[1:0];
      line_iface_strap <= strap_q[3:2];
      case (strap_q[1:0])
        `MPSC_OSC_1M8: uart_clk_hz_q <= `MPSC_HZ_1M8;
        `MPSC_OSC_3M6: uart_clk_hz_q <= `MPSC_HZ_3M6;
        `MPSC_OSC_7M3: uart_clk_hz_q <= `MPSC_HZ_7M3;
        default: uart_clk_hz_q <= `MPSC_HZ_14M7;
      endcase
      case (strap_q[3:2])
        `MPSC_IF_RS232: line_type_q <= `MPSC_LT_RS232;
        `MPSC_IF_RS422: line_type_q <= `MPSC_LT_RS422;
        `MPSC_IF_RS485: line_type_q <= `MPSC_LT_RS485;
        default: line_type_q <= `MPSC_LT_UNKNOWN;
      endcase
    end
  end

  // ********************************
  // daisy chain and population
  // ********************************

  // next-state values of the chain and population registers
  reg [3:0] pop_d;
  reg [1:0] chain_d;

  // chain carries count of units ahead; this unit adds one, saturating at three
  always @* begin
    chain_d = 2'h0;
    pop_d = `MPSC_POP_NONE;
    if (mode_s) begin
      if (chain_s == `MPSC_UNITS_MAX) begin
        chain_d = `MPSC_UNITS_MAX;
      end else begin
        chain_d = chain_s + 2'h1;
      end
      case (chain_s)
        2'h0: pop_d = `MPSC_POP_8;
        2'h1: pop_d = `MPSC_POP_16;
        2'h2: pop_d = `MPSC_POP_24;
        default: pop_d = `MPSC_POP_32;
      endcase
    end
  end

  // pins turn to outputs only after the window and only in expansion mode
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      expansion_mode_q <= 1'b0;
      chain_out <= 2'h0;
      port_population_n <= `MPSC_POP_NONE;
      dual_pin_out <= 4'h0;
      dual_pin_oe <= 4'h0;
    end else begin
      expansion_mode_q <= mode_s;
      chain_out <= chain_d;
      port_population_n <= pop_d;
      dual_pin_out <= pop_d;
      dual_pin_oe <= {4{strap_done_q & mode_s}};
    end
  end

  // ********************************
  // expansion address decode
  // ********************************

  // normal mode leaves the unit field unused, so every address hits
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unit_hit_q <= 1'b0;
      chan_sel_q <= 3'h0;
      reg_sel_q <= 3'h0;
    end else begin
      if (mode_s) begin
        unit_hit_q <= (addr[`MPSC_ADDR_UNIT_HI:`MPSC_ADDR_UNIT_LO] == chain_s);
      end else begin
        unit_hit_q <= 1'b1;
      end
      chan_sel_q <= addr[`MPSC_ADDR_CHAN_HI:`MPSC_ADDR_CHAN_LO];
      reg_sel_q <= addr[`MPSC_ADDR_REG_HI:`MPSC_ADDR_REG_LO];
    end
  end

  // ********************************
  // clock prescaler
  // ********************************

  // an async reset may not load a pin, so the select is taken once the
  // synchroniser has settled, four cycles after release; the board must
  // therefore hold the select level for a few cycles past reset
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sel_taken_q <= 1'b0;
      div4_q <= 1'b0;
      modem_control_reg_b7 <= 1'b0;
    end else if (!sel_taken_q && strap_cnt_q == `MPSC_SEL_TAKE) begin
      sel_taken_q <= 1'b1;
      div4_q <= ~sel_s;
      modem_control_reg_b7 <= ~sel_s;
    end
  end

  // one-cycle enable: every cycle for divide-by-1, every fourth for divide-by-4
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_q <= 2'h0;
      prescale_en_q <= 1'b0;
    end else if (!sel_taken_q) begin
      pre_cnt_q <= 2'h0;
      prescale_en_q <= 1'b0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 2'h1;
      prescale_en_q <= ~div4_q | (pre_cnt_q == `MPSC_DIV4_LAST);
    end
  end

endmodule

`default_nettype wire

//--- core/mpsc_defs.vh
`ifndef MPSC_DEFS_VH
`define MPSC_DEFS_VH

// strap capture window after reset release, in clock cycles
`define MPSC_STRAP_CYCLES 5'h10
`define MPSC_STRAP_CNT_W 5

// select sample point, once the synchroniser shows the pin level
`define MPSC_SEL_TAKE 5'h04

// oscillator strap codes and rates in hertz
`define MPSC_OSC_1M8 2'h0
`define MPSC_OSC_3M6 2'h1
`define MPSC_OSC_7M3 2'h2
`define MPSC_OSC_14M7 2'h3
`define MPSC_HZ_1M8 24'h1c2000
`define MPSC_HZ_3M6 24'h384000
`define MPSC_HZ_7M3 24'h708000
`define MPSC_HZ_14M7 24'he10000

// interface strap codes and one-hot line types
`define MPSC_IF_RS232 2'h0
`define MPSC_IF_RS422 2'h1
`define MPSC_IF_RS485 2'h2
`define MPSC_IF_UNKNOWN 2'h3
`define MPSC_LT_RS232 4'h1
`define MPSC_LT_RS422 4'h2
`define MPSC_LT_RS485 4'h4
`define MPSC_LT_UNKNOWN 4'h8

// port population thermometer codes
`define MPSC_POP_NONE 4'h0
`define MPSC_POP_8 4'h1
`define MPSC_POP_16 4'h3
`define MPSC_POP_24 4'h7
`define MPSC_POP_32 4'hf

// chain limits
`define MPSC_UNITS_MAX 2'h3

// prescaler divide-by-4 count
`define MPSC_DIV4_LAST 2'h3

// expansion address fields
`define MPSC_ADDR_UNIT_HI 7
`define MPSC_ADDR_UNIT_LO 6
`define MPSC_ADDR_CHAN_HI 5
`define MPSC_ADDR_CHAN_LO 3
`define MPSC_ADDR_REG_HI 2
`define MPSC_ADDR_REG_LO 0

`endif

//--- core/mpsc_sync3.v
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser; output moves only once stages two and three agree
module mpsc_sync3 #(
  parameter W = 1
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // asynchronous level in, filtered level out
  input wire [W-1:0] async_in,
  output reg [W-1:0] level_q
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  integer i;

  // s1 feeds only s2, so metastability never reaches the compare
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      level_q <= {W{1'b0}};
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_q[i] == s3_q[i]) begin
          level_q[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- tb/mpsc_board.sv
`timescale 1ns/100ps
`default_nettype none
// board side: strap resistors on the dual-role pins
module mpsc_board (
  // strap levels and device drive
  input wire logic [3:0] strap,
  input wire logic [3:0] dual_pin_out,
  input wire logic [3:0] dual_pin_oe,
  // resolved pin level
  output logic [3:0] pin
);
  // a driven pin follows the device, an undriven one its strap
  assign pin = (dual_pin_oe & dual_pin_out) | (~dual_pin_oe & strap);
endmodule
`default_nettype wire

//--- tb/mpsc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module mpsc_chk (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // watched ports
  input wire logic [7:0] addr,
  input wire logic [1:0] chain_out,
  input wire logic [3:0] dual_pin_out,
  input wire logic [3:0] dual_pin_oe,
  input wire logic [2:0] chan_sel_q,
  input wire logic [2:0] reg_sel_q,
  input wire logic [1:0] osc_freq_strap,
  input wire logic [1:0] line_iface_strap,
  input wire logic [23:0] uart_clk_hz_q,
  input wire logic [3:0] line_type_q,
  input wire logic [3:0] port_population_n,
  input wire logic strap_done_q,
  input wire logic modem_control_reg_b7,
  input wire logic prescale_en_q
);
  // ******
  // properties
  // ******
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_oe_window: assert property (!strap_done_q |-> dual_pin_oe == 4'h0)
    else $error("pins driven in capture window");
  a_pop_pins: assert property (dual_pin_oe == 4'hf && $stable(port_population_n)
    |-> dual_pin_out == port_population_n) else $error("pins lose population");
  a_pop_thermo: assert property (chain_out == 2'h2 |-> port_population_n == 4'h3)
    else $error("population wrong");
  a_addr_fields: assert property (1 |=> {chan_sel_q, reg_sel_q} == $past(addr[5:0]))
    else $error("address split wrong");
  a_strap_kept: assert property (strap_done_q |=> strap_done_q &&
    $stable({osc_freq_strap, line_iface_strap})) else $error("strap moved");
  a_osc_rate: assert property (strap_done_q
    |-> uart_clk_hz_q == (24'h1c2000 << osc_freq_strap)) else $error("rate wrong");
  a_iface_type: assert property (strap_done_q
    |-> line_type_q == (4'h1 << line_iface_strap)) else $error("line type wrong");
  a_b7_held: assert property ($past(resetn, 6) |-> $stable(modem_control_reg_b7))
    else $error("control bit moved");
  a_div4_gap: assert property (modem_control_reg_b7 && prescale_en_q
    |=> !prescale_en_q [*3] ##1 prescale_en_q) else $error("divide gap wrong");
  // main scenarios reached
  c_pins_out: cover property (strap_done_q && dual_pin_oe == 4'hf);
  c_pop_full: cover property (port_population_n == 4'hf);
  c_div1: cover property (!modem_control_reg_b7 && prescale_en_q);
endmodule
bind mpsc_top mpsc_chk u_chk (.*);
`default_nettype wire

//--- tb/mpsc_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module mpsc_tb_top;
  logic clk = 0, resetn = 0, mode = 0, sel = 0;
  logic [1:0] chain = 0, chain_out, osc_freq_strap, line_iface_strap;
  logic [3:0] strap = 0, pin, dual_pin_out, dual_pin_oe, line_type_q, port_population_n;
  logic [7:0] addr = 0;
  logic [2:0] chan_sel_q, reg_sel_q;
  logic [23:0] uart_clk_hz_q;
  logic unit_hit_q, expansion_mode_q, strap_done_q, modem_control_reg_b7, prescale_en_q;
  int num_errors = 0, check_count = 0, cyc = 0, n_en = 0;
  // free-running 100 MHz clock
  always #5 clk = ~clk;
  mpsc_top u_dut (.clk, .resetn, .multiport_expansion(mode), .prescale_select(sel),
    .chain_in(chain), .chain_out, .dual_pin_in(pin), .dual_pin_out, .dual_pin_oe, .addr,
    .unit_hit_q, .chan_sel_q, .reg_sel_q, .expansion_mode_q, .osc_freq_strap, .line_iface_strap,
    .uart_clk_hz_q, .line_type_q, .port_population_n, .strap_done_q,
    .modem_control_reg_b7, .prescale_en_q);
  mpsc_board u_board (.strap, .dual_pin_out, .dual_pin_oe, .pin);
  // ******
  // helpers
  // ******
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // units up to and including this one, as a thermometer
  function automatic logic [3:0] pop(input logic [1:0] c);
    return ~(4'he << c);
  endfunction
  // hang guard, well above the eight passes of about 60 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  // each pass resets mid-run with new straps
  initial begin
    void'($urandom(32'hd86b));
    for (int i = 0; i < 8; i++) begin
      resetn = 0;
      mode = (i != 2) && (i != 5);
      sel = $urandom;
      chain = $urandom;
      strap = {~i[1:0], i[1:0]};
      tick(8);
      chk(strap_done_q, 0);
      chk(dual_pin_oe, 0);
      chk(uart_clk_hz_q, 24'h1c2000);
      chk(chain_out, 0);
      resetn = 1;
      tick(25);
      chk(modem_control_reg_b7, {~sel});
      chk(expansion_mode_q, mode);
      chk(strap_done_q, 1);
      chk(osc_freq_strap, strap[1:0]);
      chk(line_iface_strap, strap[3:2]);
      chk(uart_clk_hz_q, 24'h1c2000 << strap[1:0]);
      chk(line_type_q, 4'h1 << strap[3:2]);
      chk(dual_pin_oe, mode ? 4'hf : 4'h0);
      chk(chain_out, mode ? (chain == 2'h3 ? chain : chain + 2'h1) : 2'h0);
      chk(port_population_n, mode ? pop(chain) : 4'h0);
      if (mode) chk(dual_pin_out, pop(chain));
      // eight cycles hold eight enables at divide-by-1, two at divide-by-4
      n_en = 0;
      repeat (8) begin
        tick(1);
        n_en += prescale_en_q;
      end
      chk(n_en, sel ? 8 : 2);
      // late strap moves are ignored, chain moves are followed
      strap = ~strap;
      chain = chain + 2'h1;
      tick(8);
      chk(osc_freq_strap, {~strap[1:0]});
      chk(port_population_n, mode ? pop(chain) : 4'h0);
      repeat (6) begin
        addr = $urandom;
        tick(1);
        chk({chan_sel_q, reg_sel_q}, addr[5:0]);
        chk(unit_hit_q, mode ? addr[7:6] == chain : 1'b1);
      end
    end
    wrap_up();
  end
endmodule
`default_nettype wire
